// *** tb_uart_char_data_port.sv ***
// self-checking bench for the character data port
// assumes the radio model on the serial side and an AXI4-Lite master driven here
`timescale 1ns/1ps
module tb_uart_char_data_port;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] awAddr = 4'h0;
  logic [3:0] arAddr = 4'h0;
  logic [3:0] wStrb = 4'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, rxd, txd, irq;
  logic [1:0] bResp, rResp, resp;
  logic [31:0] rData, rd;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  ucd_char_port ucd_char_port_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .rxd(rxd), .txd(txd), .irq(irq));
  ucd_radio_model ucd_radio_model_inst (.clk(clk), .rxdLine(rxd), .txdLine(txd));

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and hang guard share one exit
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %08h expected %08h", $time, seen, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: address and data offered together, each released when taken
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    wStrb <= 4'hF;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && awReady === 1'b1) begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (!wDone && wReady === 1'b1) begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    while (bValid !== 1'b1) @(posedge clk);
    r = bResp;
    bReady <= 1'b0;
  endtask

  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge clk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1) @(posedge clk);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask

  // defined fields only: reserved bits are not judged
  function automatic logic [31:0] rxWord(input logic [7:0] n, input logic pe, input logic [8:0] c);
    return {8'h00, n, n != 8'h00, 5'h00, pe, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic testReset;
    axiRead(ucd_pkg::CHAR_FIFO_PORT_OFS, rd, resp);
    check(rd & 32'h00FF83FF, 32'h0);
    check({30'h0, resp}, {30'h0, ucd_pkg::RESP_OKAY});
    axiRead(ucd_pkg::IRQ_STATUS_OFS, rd, resp);
    check(rd & 32'h7, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  task automatic testBusErrors;
    axiWrite(4'h1, 32'h0, resp);
    check({30'h0, resp}, {30'h0, ucd_pkg::RESP_SLVERR});
    axiRead(4'h3, rd, resp);
    check({30'h0, resp}, {30'h0, ucd_pkg::RESP_SLVERR});
  endtask

  // 8-bit characters, even parity
  task automatic testConfig;
    axiWrite(ucd_pkg::CFG_OFS, 32'h6, resp);
    check({30'h0, resp}, {30'h0, ucd_pkg::RESP_OKAY});
    axiRead(ucd_pkg::CFG_OFS, rd, resp);
    check(rd & 32'h00FF000F, {8'h00, 8'(ucd_pkg::FIFO_DEPTH), 16'h0006});
  endtask

  task automatic testRxCommand;
    logic [7:0] cmd [3];
    cmd = '{8'h4F, 8'h4B, 8'h0A};
    axiWrite(ucd_pkg::IRQ_MASK_OFS, 32'h1, resp);
    foreach (cmd[i]) ucd_radio_model_inst.sendChar(cmd[i], 1'b0);
    repeat (4) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    // host loop: keep each character until line feed
    foreach (cmd[i]) begin
      axiRead(ucd_pkg::CHAR_FIFO_PORT_OFS, rd, resp);
      check(rd & 32'h00FF83FF, rxWord(8'(3 - i), 1'b0, {1'b0, cmd[i]}));
      check({24'h0, rd[7:0]}, {24'h0, cmd[i]});
    end
    axiRead(ucd_pkg::CHAR_FIFO_PORT_OFS, rd, resp);
    check(rd & 32'h00FF83FF, 32'h0);
    axiWrite(ucd_pkg::IRQ_STATUS_OFS, 32'h1, resp);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask

  // masked event: status sticks, interrupt stays low
  task automatic testParity;
    axiWrite(ucd_pkg::IRQ_MASK_OFS, 32'h0, resp);
    ucd_radio_model_inst.sendChar(8'h33, 1'b1);
    repeat (4) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    axiRead(ucd_pkg::IRQ_STATUS_OFS, rd, resp);
    check(rd & 32'h1, 32'h1);
    axiRead(ucd_pkg::CHAR_FIFO_PORT_OFS, rd, resp);
    check(rd & 32'h00FF83FF, rxWord(8'h01, 1'b1, 9'h033));
  endtask

  // bit 8 set must not stretch an 8-bit frame
  task automatic testTx;
    int n;
    n = 0;
    axiWrite(ucd_pkg::CHAR_FIFO_PORT_OFS, 32'h000001A5, resp);
    while (ucd_radio_model_inst.frames == 0 && n < 15000) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, ucd_radio_model_inst.frames == 1}, 32'h1);
    check({24'h0, ucd_radio_model_inst.lastChar}, 32'h000000A5);
    check({31'h0, ucd_radio_model_inst.lastParity}, 32'h0);
  endtask

  // overfill the transmit fifo: surplus writes are dropped and flagged, irq stays masked
  task automatic testTxDrop;
    for (int k = 0; k < 140; k++) axiWrite(ucd_pkg::CHAR_FIFO_PORT_OFS, 32'h55, resp);
    axiRead(ucd_pkg::IRQ_STATUS_OFS, rd, resp);
    check(rd & 32'h4, 32'h4);
    axiRead(ucd_pkg::CFG_OFS, rd, resp);
    check(rd & 32'h00FF0000, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    testReset();
    testBusErrors();
    testConfig();
    testRxCommand();
    testParity();
    testTx();
    testTxDrop();
    complete_run();
  end
endmodule // tb_uart_char_data_port

// *** ucd_char_port.sv ***
// character data port of a serial core: AXI4-Lite slave, rx/tx fifos, 7/8/9-bit serial, parity none/even/odd
// assumes rxd is asynchronous; master keeps one read and one write in flight
`timescale 1ns/1ps
module ucd_char_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  localparam int CW = ucd_pkg::CHAR_W;
  localparam int AW = ucd_pkg::FIFO_AW;
  localparam logic [15:0] DIV = 16'(ucd_pkg::BAUD_DIV);

  logic [3:0] cfg; // [3:2] width code 0=7 1=8 2=9, [1] parity enable, [0] odd parity
  logic [2:0] irqStatus;
  logic [2:0] irqMask;
  logic awHeld, wHeld;
  logic [3:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic rdPending;
  logic [3:0] arAddr;
  logic rxPush, rxPop, txPush, txPop;
  logic [CW:0] rxWr, rxRd;
  logic [CW-1:0] txRd;
  logic [AW:0] rxCount, txCount;
  logic rxOverrun, txDrop;
  logic [CW-1:0] widthMask;

  ////////////////////////////////////////////////////////////////////////////
  // character width mask from configuration
  always_comb begin
    case (cfg[3:2])
      2'h0: widthMask = 9'h07F;
      2'h1: widthMask = 9'h0FF;
      default: widthMask = 9'h1FF;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channels: address and data latched in either order
  wire writeGo = awHeld && wHeld && !s_axi_bvalid;
  // ready flags are registered from the next held state, so no output is combinational
  wire next_awHeld = (awHeld || (s_axi_awvalid && s_axi_awready)) && !writeGo;
  wire next_wHeld = (wHeld || (s_axi_wvalid && s_axi_wready)) && !writeGo;
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awAddr <= 4'h0;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ucd_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (writeGo) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr[1:0] == 2'h0) ? ucd_pkg::RESP_OKAY : ucd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_awready <= !next_awHeld;
      s_axi_wready <= !next_wHeld;
    end
  end

  // transmit push: only the character field, masked to width; full fifo drops
  assign txPush = writeGo && awAddr == ucd_pkg::CHAR_FIFO_PORT_OFS && wStrb[0] // RQ3
    && txCount != (AW+1)'(ucd_pkg::FIFO_DEPTH);
  assign txDrop = writeGo && awAddr == ucd_pkg::CHAR_FIFO_PORT_OFS && wStrb[0]
    && txCount == (AW+1)'(ucd_pkg::FIFO_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // configuration and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= ucd_pkg::CFG_RESET;
      irqMask <= ucd_pkg::IRQ_RESET;
    end else if (writeGo && wStrb[0]) begin
      if (awAddr == ucd_pkg::CFG_OFS) begin
        cfg <= wData[3:0];
      end
      if (awAddr == ucd_pkg::IRQ_MASK_OFS) begin
        irqMask <= wData[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status; a new event wins over a write-one clear
  wire [2:0] irqEvent = {txDrop, rxOverrun, rxPush};
  wire [2:0] irqClear = (writeGo && wStrb[0] && awAddr == ucd_pkg::IRQ_STATUS_OFS)
    ? wData[2:0] : 3'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatus <= ucd_pkg::IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
      irq <= |(((irqStatus & ~irqClear) | irqEvent) & irqMask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: pop one entry, answer two cycles after address taken
  logic rdStage;
  logic [AW:0] countSnap;
  // arready is the registered inverse of the next pending state
  wire next_rdPending = (rdPending || (s_axi_arvalid && s_axi_arready))
    && !(s_axi_rvalid && s_axi_rready);
  assign rxPop = s_axi_arvalid && s_axi_arready // RQ13
    && s_axi_araddr == ucd_pkg::CHAR_FIFO_PORT_OFS && rxCount != '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdPending <= 1'b0;
      rdStage <= 1'b0;
      s_axi_arready <= 1'b0;
      arAddr <= 4'h0;
      countSnap <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= ucd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rdPending;
      if (s_axi_arvalid && s_axi_arready) begin
        rdPending <= 1'b1;
        rdStage <= 1'b1;
        arAddr <= s_axi_araddr;
        countSnap <= rxPop ? rxCount : '0; // RQ7
      end
      if (rdStage) begin
        rdStage <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (arAddr[1:0] == 2'h0) ? ucd_pkg::RESP_OKAY : ucd_pkg::RESP_SLVERR;
        s_axi_rdata <= 32'h0; // RQ1
        case (arAddr)
          ucd_pkg::CHAR_FIFO_PORT_OFS: begin // RQ8
            if (countSnap != '0) begin
              s_axi_rdata[CW-1:0] <= rxRd[CW-1:0] & widthMask; // RQ4 RQ2 RQ9
              s_axi_rdata[ucd_pkg::PE_BIT] <= rxRd[CW]; // RQ5
              s_axi_rdata[ucd_pkg::VALID_BIT] <= 1'b1; // RQ6
            end
            s_axi_rdata[ucd_pkg::COUNT_LSB +: 8] <= 8'(countSnap); // RQ7
          end
          ucd_pkg::CFG_OFS: begin
            s_axi_rdata[3:0] <= cfg;
            s_axi_rdata[ucd_pkg::COUNT_LSB +: 8] <= 8'(ucd_pkg::FIFO_DEPTH - int'(txCount));
          end
          ucd_pkg::IRQ_STATUS_OFS: s_axi_rdata[2:0] <= irqStatus;
          ucd_pkg::IRQ_MASK_OFS: s_axi_rdata[2:0] <= irqMask;
          default: s_axi_rdata <= 32'h0;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        rdPending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifos
  ucd_fifo #(.W(CW+1), .AW(AW)) rxFifo (
    .clk(clk), .rst(rst), .push(rxPush), .wrData(rxWr), .pop(rxPop),
    .rdData(rxRd), .count(rxCount)
  );
  ucd_fifo #(.W(CW), .AW(AW)) txFifo (
    .clk(clk), .rst(rst), .push(txPush), .wrData(wData[CW-1:0] & widthMask), .pop(txPop),
    .rdData(txRd), .count(txCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: 1 start, data lsb first, optional parity, 1 stop at 115200
  typedef enum logic [2:0] {TX_IDLE = 3'h1, TX_LOAD = 3'h2, TX_SHIFT = 3'h4} ucd_tx_t;
  ucd_tx_t txState;
  logic [15:0] txTick;
  logic [11:0] txShift;
  logic [3:0] txBits;
  wire [3:0] nBits = 4'(cfg[3:2] == 2'h0 ? 7 : cfg[3:2] == 2'h1 ? 8 : 9);
  wire [3:0] frameLen = nBits + {3'h0, cfg[1]} + 4'h2;
  wire txPar = ^(txRd & widthMask) ^ cfg[0];
  assign txPop = txState == TX_IDLE && txCount != '0;
  always_ff @(posedge clk) begin
    if (rst) begin
      txState <= TX_IDLE;
      txTick <= 16'h0;
      txShift <= 12'hFFF;
      txBits <= 4'h0;
      txd <= 1'b1;
    end else begin
      case (txState)
        TX_IDLE: if (txPop) txState <= TX_LOAD;
        TX_LOAD: begin
          // frame is built lsb first; bits past frame end are idle ones, except bit 9 of a 7-bit frame without parity
          txShift <= {1'b1, 11'h7FF} & ~(12'h1);
          txShift[CW:1] <= txRd & widthMask;
          if (cfg[1]) txShift[nBits+1] <= txPar;
          txShift[nBits+{3'h0, cfg[1]}+1] <= 1'b1;
          txBits <= frameLen;
          txTick <= DIV; // RQ12
          txState <= TX_SHIFT;
        end
        TX_SHIFT: begin
          txd <= txShift[0];
          if (txTick == 16'h1) begin
            txTick <= DIV;
            txShift <= {1'b1, txShift[11:1]};
            txBits <= txBits - 4'h1;
            if (txBits == 4'h1) txState <= TX_IDLE;
          end else begin
            txTick <= txTick - 16'h1;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: three-stage sync, mid-bit sampling, parity check
  logic [2:0] rxSync;
  logic rxLine;
  always_ff @(posedge clk) begin
    if (rst) begin
      rxSync <= 3'h7;
      rxLine <= 1'b1;
    end else begin
      rxSync <= {rxSync[1:0], rxd};
      if (rxSync[2] == rxSync[1]) rxLine <= rxSync[1];
    end
  end
  logic rxBusy;
  logic [15:0] rxTick;
  logic [3:0] rxIdx;
  logic [10:0] rxBuf;
  logic [10:0] rxNow;
  wire [3:0] rxLast = nBits + {3'h0, cfg[1]} - 4'h1;
  // samples so far with the one being taken merged in
  always_comb begin
    rxNow = rxBuf;
    rxNow[rxIdx] = rxLine;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      rxBusy <= 1'b0;
      rxTick <= 16'h0;
      rxIdx <= 4'h0;
      rxBuf <= 11'h0;
      rxPush <= 1'b0;
      rxOverrun <= 1'b0;
      rxWr <= '0;
    end else begin
      rxPush <= 1'b0;
      rxOverrun <= 1'b0;
      if (!rxBusy) begin
        if (!rxLine) begin
          rxBusy <= 1'b1;
          rxTick <= DIV + (DIV >> 1); // first sample mid data bit 0
          rxIdx <= 4'h0;
        end
      end else if (rxTick == 16'h1) begin
        rxTick <= DIV;
        rxBuf[rxIdx] <= rxLine;
        rxIdx <= rxIdx + 4'h1;
        if (rxIdx == rxLast) begin
          // character taken at last data or parity bit; parity bit sits at index nBits
          rxWr[CW-1:0] <= rxNow[CW-1:0] & widthMask;
          rxWr[CW] <= cfg[1] & (^(rxNow[CW-1:0] & widthMask) ^ rxNow[nBits] ^ cfg[0]);
          if (rxCount == (AW+1)'(ucd_pkg::FIFO_DEPTH)) rxOverrun <= 1'b1;
          else rxPush <= 1'b1;
        end
        if (rxIdx == rxLast + 4'h1) begin
          // stay busy to mid stop bit: a low last bit must not look like a start
          rxBusy <= 1'b0;
        end
      end else begin
        rxTick <= rxTick - 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_empty_read_zero: assert property (@(posedge clk) disable iff (rst) // RQ13
    (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0 && rxCount == '0)
    |=> ##1 (s_axi_rdata[31:15] == 17'h0)) else $error("empty read not zero");
  a_valid_with_count: assert property (@(posedge clk) disable iff (rst) // RQ6
    $rose(s_axi_rvalid) && arAddr == 4'h0 |-> s_axi_rdata[15] == (s_axi_rdata[23:16] != 8'h0))
    else $error("valid flag disagrees with count");
  a_pop_count_drop: assert property (@(posedge clk) disable iff (rst) // RQ4
    rxPop && !rxPush |=> rxCount == $past(rxCount) - 1'b1) else $error("pop lost");
  a_count_reported: assert property (@(posedge clk) disable iff (rst) // RQ7
    rxPop |-> ##2 s_axi_rdata[23:16] == 8'($past(rxCount, 2))) else $error("bad count");
  a_width_mask: assert property (@(posedge clk) disable iff (rst) // RQ2
    $rose(s_axi_rvalid) && arAddr == 4'h0 |-> (s_axi_rdata[8:0] & ~widthMask) == 9'h0)
    else $error("bits above width set");
  a_tx_push: assert property (@(posedge clk) disable iff (rst) // RQ3
    txPush && !txPop |=> txCount == $past(txCount) + 1'b1) else $error("tx push lost");
  a_read_answer: assert property (@(posedge clk) disable iff (rst) // RQ8
    s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid) else $error("read late");
  a_write_answer: assert property (@(posedge clk) disable iff (rst) // RQ8
    writeGo |=> s_axi_bvalid) else $error("write response late");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == |(irqStatus & $past(irqMask))) else $error("irq wrong");
  a_empty_no_pop: assert property (@(posedge clk) disable iff (rst) // RQ13
    s_axi_arvalid && s_axi_arready && rxCount == '0 && !rxPush |=> rxCount == '0)
    else $error("empty read moved fifo");
  a_pe_needs_valid: assert property (@(posedge clk) disable iff (rst) // RQ5
    $rose(s_axi_rvalid) && arAddr == 4'h0 && !s_axi_rdata[15] |-> !s_axi_rdata[9])
    else $error("parity flag without character");
  a_rx_push_count: assert property (@(posedge clk) disable iff (rst) // RQ4
    rxPush && !rxPop |=> rxCount == $past(rxCount) + 1'b1) else $error("rx push lost");
  a_txd_idle_high: assert property (@(posedge clk) disable iff (rst)
    txState == TX_IDLE |-> txd) else $error("line not idle high");
  a_one_read_open: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
  c_read_char: cover property (@(posedge clk) rxPop ##2 s_axi_rvalid);
  c_tx_frame: cover property (@(posedge clk) txState == TX_LOAD);
  c_rx_char: cover property (@(posedge clk) rxPush);
  c_empty_read: cover property (@(posedge clk) s_axi_arvalid && s_axi_arready && rxCount == '0);
endmodule // ucd_char_port

// *** ucd_fifo.sv ***
// small synchronous fifo with registered read data
// assumes single clock; pop only when not empty, push only when not full
`timescale 1ns/1ps
module ucd_fifo #(
  parameter int W = 10,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [W-1:0] wrData,
  input wire logic pop,
  output logic [W-1:0] rdData,
  output logic [AW:0] count
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  // storage and registered read port, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= wrData;
    end
    if (pop) begin
      rdData <= mem[rdPtr];
    end
  end
  // pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ucd_fifo

// *** ucd_pkg.sv ***
// constants shared by the character data port and its fifo
// assumes a 100 MHz system clock and an AXI4-Lite master outside
// Summary of operation
// RQ1 - reserved register bits read undefined; host writes zeros there
// RQ2 - character bits above the configured width read zero, writes ignored
// RQ3 - a write to the character register pushes bits 8..0 to transmit fifo
// RQ4 - a read returns the oldest received character, popped from receive fifo
// RQ5 - bit 9 of a read flags a parity error on that character
// RQ6 - bit 15 of a read marks character and parity flag as genuine
// RQ7 - bits 23..16 give characters remaining in receive fifo, this one included
// RQ8 - the character register is 32 bits wide at offset zero
// RQ9 - each read delivers one character only; commands need repeated reads
// RQ10 - host treats nonzero count as valid and keeps the low 8 bits
// RQ11 - host collects characters until line feed, then restarts collecting
// RQ12 - the serial link runs at 115200 baud
// RQ13 - a read of an empty receive fifo returns valid and count zero, no pop
package ucd_pkg;
  localparam logic [3:0] CHAR_FIFO_PORT_OFS = 4'h0;
  localparam logic [3:0] CFG_OFS = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
  localparam int PE_BIT = 9;
  localparam int VALID_BIT = 15;
  localparam int COUNT_LSB = 16;
  localparam int CHAR_W = 9;
  localparam int FIFO_AW = 7;
  localparam int FIFO_DEPTH = 128;
  localparam logic [3:0] CFG_RESET = 4'h8;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int IRQ_RX_AVAIL = 0;
  localparam int IRQ_RX_OVERRUN = 1;
  localparam int IRQ_TX_FULL_DROP = 2;
  localparam int BAUD_RATE = 115200;
  localparam int CLK_HZ = 100000000;
  localparam int BAUD_DIV = CLK_HZ / BAUD_RATE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** ucd_radio_model.sv ***
// behavioural model of the wireless module on the far side of the serial link
// assumes 8 data bits, even parity, one stop bit, lsb first, as the bench configures
`timescale 1ns/1ps
module ucd_radio_model (
  input wire logic clk,
  output logic rxdLine,
  input wire logic txdLine
);
  logic [7:0] lastChar;
  logic lastParity;
  int frames;

  // idle line is high between frames
  initial begin
    rxdLine = 1'b1;
    lastChar = 8'h00;
    lastParity = 1'b0;
    frames = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // send one frame; badPar flips the parity bit on purpose
  task automatic sendChar(input logic [7:0] c, input logic badPar);
    logic [10:0] f;
    f = {1'b1, (^c) ^ badPar, c, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rxdLine <= f[i];
      repeat (ucd_pkg::BAUD_DIV) @(posedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // capture frames from the core; mid-bit sampling tolerates small skew
  always begin : capture
    logic [7:0] d;
    @(negedge txdLine);
    repeat (ucd_pkg::BAUD_DIV / 2) @(posedge clk);
    if (txdLine == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (ucd_pkg::BAUD_DIV) @(posedge clk);
        d[i] = txdLine;
      end
      repeat (ucd_pkg::BAUD_DIV) @(posedge clk);
      lastParity = txdLine;
      repeat (ucd_pkg::BAUD_DIV) @(posedge clk);
      lastChar = d;
      frames++;
    end
  end
endmodule // ucd_radio_model
